// [rtl/sraf_regs.svh]
`ifndef SRAF_REGS_SVH
`define SRAF_REGS_SVH

// ----------------------------------------------------------------
// Frame layout and command codes
// ----------------------------------------------------------------
`define SRAF_FRAME_BITS 6'd32
`define SRAF_CMD_READ 4'hc
`define SRAF_CMD_WRITE 4'h8
`define SRAF_RSP_READ 4'h6
`define SRAF_RSP_WRITE 4'h4
`define SRAF_STATUS_ERROR 2'h3
`define SRAF_RES_PAD 4'h0

// ----------------------------------------------------------------
// CRC generator x^8+x^5+x^3+x^2+x+1 and seed
// ----------------------------------------------------------------
`define SRAF_CRC_POLY 8'h2f
`define SRAF_CRC_SEED 8'hff

// ----------------------------------------------------------------
// Lock/write register and its software reset field
// ----------------------------------------------------------------
`define SRAF_LOCK_ADDR 8'h10
`define SRAF_RESET_MASK 8'h03
`define SRAF_FULL_MASK 8'hff

`endif

// [rtl/sraf_pkg.sv]
package sraf_pkg;

   // Link state, Gray coded
   typedef enum logic [0:0] {
      SRAF_IDLE = 1'b0,
      SRAF_XFER = 1'b1
   } sraf_state_t;

   // Kind of response queued for the next frame
   typedef enum logic [1:0] {
      SRAF_PK_ERR = 2'h0,
      SRAF_PK_READ = 2'h1,
      SRAF_PK_WRITE = 2'h2,
      SRAF_PK_SENSOR = 2'h3
   } sraf_kind_t;

   // Whole state of the framer
   typedef struct packed {
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic ss_m;
      logic ss_s;
      logic ss_p;
      logic mosi_m;
      logic mosi_s;
      sraf_state_t phase;
      logic [31:0] rx;
      logic [5:0] cnt;
      logic [31:0] tx;
      sraf_kind_t pk;
      logic [3:0] pcmd;
      logic [15:0] pdat;
      logic wr;
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } sraf_state_s_t;

endpackage

// [rtl/sraf_frame.sv]
`include "sraf_regs.svh"

// Function
// (R1) Read response: 0110, status, word, CRC
// (R2) Bits 23:16 carry odd (high) byte
// (R3) Bits 15:8 carry even (low) byte
// (R4) Host writes with code 1000, zeros after
// (R5) Host puts byte address in bits 23:16
// (R6) Host puts data byte then CRC
// (R7) Valid write stores byte at address
// (R8) Write only without framing, CRC, output errors
// (R9) Lock bit blocks register writes
// (R10) Reset field stays writable when locked
// (R11) Failed write changes nothing, error response
// (R12) Register updates after select rises
// (R13) Read-only target: no change, valid response
// (R14) Write response: 0100, status, word, CRC
// (R15) Write response in the next frame
// (R16) Sensor response in next frame unless error
// (R17) Sensor value captured at select fall
// (R18) Host reads with code 1100, word address
// (R19) Read data captured at select rise
// (R20) CRC over 32 bits, mismatch gives error
// (R21) Sensor request has lowest command bit set
// (R22) Bits 25:24 of register responses zero
// (R23) Response shifted out MSB first, CRC last
module sraf_frame import sraf_pkg::*; (
   input wire logic core_clk_i,            // System clock, 100 MHz
   input wire logic sys_rst_i,             // Sync reset, active high
   input wire logic sclk_i,                // SPI clock pin
   input wire logic ss_n_i,                // SPI select pin, low active
   input wire logic mosi_i,                // SPI data in pin
   output logic miso_o,                    // SPI data out pin
   output logic miso_oe_o,                 // Data out enable
   input wire logic miso_err_i,            // Output verification error
   input wire logic init_lock_bit_i,       // End of init lock
   input wire logic [1:0] basic_status_i,  // Basic status field
   input wire logic [1:0] detailed_status_i, // Detailed status field
   input wire logic [11:0] sensor_value_i, // Sensor data
   output logic [7:0] reg_byte_address_o,  // Address of last frame
   input wire logic [15:0] reg_rdata_i,    // Word at address
   input wire logic reg_valid_i,           // Address is accessible
   input wire logic reg_ro_i,              // Address is read only
   output logic reg_wr_o,                  // Write strobe
   output logic [7:0] reg_waddr_o,         // Write byte address
   output logic [7:0] reg_wdata_o,         // Write data byte
   output logic [7:0] reg_wmask_o          // Write bit mask
);

   // ----------------------------------------------------------------
   // CRC over the 24 leading frame bits
   // ----------------------------------------------------------------
   function automatic logic [7:0] sraf_crc8(input logic [23:0] m);
      logic [7:0] c;
      logic fb;
      c = `SRAF_CRC_SEED;
      for (int i = 23; i >= 0; i--) begin
         fb = c[7] ^ m[i];
         c = {c[6:0], 1'b0};
         if (fb) begin
            c = c ^ `SRAF_CRC_POLY;
         end
      end
      return c;
   endfunction

   sraf_state_s_t q;
   sraf_state_s_t d;
   logic ss_fall;
   logic ss_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic [23:0] hdr;
   logic frame_ok;
   logic locked_out;
   logic [3:0] cmd;

   // ----------------------------------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------------------------------
   // Two stages to settle, a third to see edges
   // Each sclk phase must last four core cycles or more
   assign ss_fall = q.ss_p & ~q.ss_s;
   assign ss_rise = ~q.ss_p & q.ss_s;
   assign sclk_rise = ~q.sclk_p & q.sclk_s & ~q.ss_s;
   assign sclk_fall = q.sclk_p & ~q.sclk_s & ~q.ss_s;
   assign cmd = q.rx[31:28];

   // Command check: length, CRC, output error
   // Bits 7:0 matching is a zero remainder check
   assign frame_ok = (q.cnt == `SRAF_FRAME_BITS) &&
                     (sraf_crc8(q.rx[31:8]) == q.rx[7:0]) && // [R20]
                     !miso_err_i;                            // [R8]

   // Lock blocks all but the lock/write register
   // Its reset field stays writable under lock
   assign locked_out = init_lock_bit_i &&
                       (q.rx[23:16] != `SRAF_LOCK_ADDR); // [R9] [R10]

   // Header of the response queued for the next frame
   // Status and sensor inputs are taken as tx loads
   always_comb begin
      unique case (q.pk)
         SRAF_PK_READ: begin
            hdr = {`SRAF_RSP_READ, basic_status_i, 2'h0, // [R1] [R22]
                   q.pdat};                              // [R2] [R3]
         end
         SRAF_PK_WRITE: begin
            hdr = {`SRAF_RSP_WRITE, basic_status_i, 2'h0, // [R14] [R22]
                   q.pdat};                               // [R2] [R3]
         end
         SRAF_PK_SENSOR: begin
            hdr = {q.pcmd, basic_status_i, sensor_value_i, // [R17]
                   `SRAF_RES_PAD, detailed_status_i};
         end
         SRAF_PK_ERR: begin
            hdr = {q.pcmd, `SRAF_STATUS_ERROR, 16'h0000, detailed_status_i};
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.wr = 1'b0;
      // Sync chains: only the second stage reads the first
      d.sclk_m = sclk_i;
      d.sclk_s = q.sclk_m;
      d.sclk_p = q.sclk_s;
      d.ss_m = ss_n_i;
      d.ss_s = q.ss_m;
      d.ss_p = q.ss_s;
      d.mosi_m = mosi_i;
      d.mosi_s = q.mosi_m;
      unique case (q.phase)
         SRAF_IDLE: begin
            // Load queued response at select fall
            if (ss_fall) begin
               d.tx = {hdr, sraf_crc8(hdr)}; // [R15] [R16] [R23]
               // Count restarts; rx refills over the frame
               d.cnt = 6'h00;
               d.phase = SRAF_XFER;
            end
         end
         SRAF_XFER: begin
            // Sample in on rising, shift out on falling
            if (sclk_rise) begin
               d.rx = {q.rx[30:0], q.mosi_s};
               if (q.cnt != 6'h3f) begin
                  d.cnt = q.cnt + 6'h01;
               end
            end
            if (sclk_fall) begin
               d.tx = {q.tx[30:0], 1'b0}; // [R23]
            end
            // Decode command once the frame is complete
            if (ss_rise) begin
               d.phase = SRAF_IDLE;
               d.pcmd = cmd;
               d.pk = SRAF_PK_ERR; // [R11]
               if (frame_ok) begin
                  if (cmd[0]) begin
                     d.pk = SRAF_PK_SENSOR; // [R16]
                  end else if (cmd == `SRAF_CMD_READ) begin
                     d.pk = SRAF_PK_READ;
                     d.pdat = reg_rdata_i; // [R19]
                  end else if (cmd == `SRAF_CMD_WRITE &&
                               q.rx[27:24] == 4'h0 &&
                               reg_valid_i && !locked_out) begin
                     d.pk = SRAF_PK_WRITE; // [R8]
                     d.pdat = reg_rdata_i;
                     // Read-only target keeps a valid answer
                     if (!reg_ro_i) begin // [R13]
                        d.wr = 1'b1; // [R7] [R12]
                        d.waddr = q.rx[23:16];
                        d.wdata = q.rx[15:8];
                        d.wmask = init_lock_bit_i ? `SRAF_RESET_MASK
                                                  : `SRAF_FULL_MASK;
                     end
                  end
               end
               // Any failure leaves the pending kind as error
               // and no strobe is raised. [R11]
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Select stages reset high, so no false edge follows
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         q <= '{sclk_m: 1'b0, sclk_s: 1'b0, sclk_p: 1'b0,
                ss_m: 1'b1, ss_s: 1'b1, ss_p: 1'b1,
                mosi_m: 1'b0, mosi_s: 1'b0, phase: SRAF_IDLE,
                rx: 32'h0, cnt: 6'h00, tx: 32'h0,
                pk: SRAF_PK_ERR, pcmd: 4'h0, pdat: 16'h0000,
                wr: 1'b0, waddr: 8'h00, wdata: 8'h00,
                wmask: 8'h00};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign miso_o = q.tx[31];
   // Enable follows the settled select
   assign miso_oe_o = ~q.ss_s;
   // Address port keeps the last frame's address until the next frame's first sclk rise
   assign reg_byte_address_o = q.rx[23:16];
   assign reg_wr_o = q.wr;
   assign reg_waddr_o = q.waddr;
   assign reg_wdata_o = q.wdata;
   assign reg_wmask_o = q.wmask;

endmodule

// [verification/sraf_frame_checker.sv]
// ----------------------------------------------------------------
// Port checker for the frame block
// ----------------------------------------------------------------
module sraf_frame_checker (
   input logic core_clk_i, // Clock
   input logic sys_rst_i, // Reset
   input logic sclk_i, // SPI clock
   input logic ss_n_i, // Select
   input logic miso_o, // Data out
   input logic miso_oe_o, // Out enable
   input logic miso_err_i, // Out error
   input logic init_lock_bit_i, // Lock
   input logic [7:0] reg_byte_address_o, // Frame address
   input logic reg_valid_i, // Accessible
   input logic reg_wr_o, // Strobe
   input logic [7:0] reg_waddr_o, // Write address
   input logic [7:0] reg_wmask_o // Write mask
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Frame start and idle select
   sequence sel_fall;
      $fell(ss_n_i);
   endsequence
   sequence sel_idle;
      ss_n_i [*6];
   endsequence
   oe_on_a: assert property (sel_fall |-> ##[2:6] miso_oe_o)
      else $error("out enable late");
   oe_off_a: assert property (sel_idle |-> !miso_oe_o)
      else $error("out enable while idle");
   miso_hold_a: assert property ($rose(sclk_i) |->
      $stable(miso_o) [*4])
      else $error("data moved at clock rise");
   wr_late_a: assert property (reg_wr_o |->
      ss_n_i && $past(ss_n_i, 3))
      else $error("write inside frame");
   wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
      else $error("write strobe too long");
   wr_lock_a: assert property (reg_wr_o && init_lock_bit_i |->
      reg_waddr_o == 8'h10 && reg_wmask_o == 8'h03)
      else $error("write while locked");
   wr_open_a: assert property (reg_wr_o && !init_lock_bit_i |->
      reg_wmask_o == 8'hff)
      else $error("unlocked write mask");
   wr_valid_a: assert property (reg_wr_o |->
      reg_valid_i && !miso_err_i && reg_waddr_o == reg_byte_address_o)
      else $error("write without valid access");
endmodule

bind sraf_frame sraf_frame_checker u_chk (.core_clk_i, .sys_rst_i, .sclk_i,
   .ss_n_i, .miso_o, .miso_oe_o, .miso_err_i, .init_lock_bit_i,
   .reg_byte_address_o, .reg_valid_i, .reg_wr_o, .reg_waddr_o, .reg_wmask_o);

// [verification/sraf_host_model.sv]
// ----------------------------------------------------------------
// SPI host: mode 0, each clock phase 8 core cycles
// ----------------------------------------------------------------
module sraf_host_model (
   input logic clk_i, // Core clock
   input logic miso_i, // Data from block
   output logic sclk_o, // SPI clock
   output logic ss_n_o, // Select, low active
   output logic mosi_o // Data to block
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle link
   initial begin
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // One 32-bit frame, clock still outside it
   task automatic xfer(input logic [31:0] c, output logic [31:0] rsp);
      ss_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      for (int i = 31; i >= 0; i--) begin
         mosi_o <= c[i];
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b1;
         rsp[i] = miso_i;
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      ss_n_o <= 1'b1;
      mosi_o <= ~mosi_o; // Released line shows no stale bit
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// [verification/sraf_frame_tb.sv]
module sraf_frame_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, err = 0, lock = 0;
   logic sclk, ss_n, mosi, miso, wr;
   logic [1:0] bstat = 2'h0, dstat = 2'h0, pk = 2'h0;
   logic [3:0] pn = 0, n;
   logic [11:0] sv = 0;
   logic [7:0] ba, wa, wd, wm;
   logic [7:0] mem [256];
   logic [7:0] ref_m [256];
   logic [15:0] pw;
   logic [23:0] h;
   logic [31:0] r, q;
   integer seed = 32'h6f23;
   int miscompares, checks_done;

   sraf_frame DUT (.core_clk_i(clk), .sys_rst_i(rst), .sclk_i(sclk),
      .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(),
      .miso_err_i(err), .init_lock_bit_i(lock), .basic_status_i(bstat),
      .detailed_status_i(dstat), .sensor_value_i(sv),
      .reg_byte_address_o(ba), .reg_rdata_i({mem[{ba[7:1], 1'b1}],
      mem[{ba[7:1], 1'b0}]}), .reg_valid_i(!ba[7]), .reg_ro_i(ba[6]),
      .reg_wr_o(wr), .reg_waddr_o(wa), .reg_wdata_o(wd), .reg_wmask_o(wm));
   sraf_host_model host (.clk_i(clk), .miso_i(miso), .sclk_o(sclk),
      .ss_n_o(ss_n), .mosi_o(mosi));

   initial forever #5 clk = ~clk;
   // Map: upper half unmapped, 40..7f read only
   always @(posedge clk) if (wr) mem[wa] <= (mem[wa] & ~wm) | (wd & wm);

   // Frame CRC, seed ff, MSB first
   function automatic logic [7:0] crc(logic [23:0] d);
      logic [7:0] c = 8'hff;
      for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ (c[7] ^ d[i] ?
         8'h2f : 8'h00);
      return c;
   endfunction

   task automatic results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Send a command, check the answer to the one before
   task automatic send(input logic [31:0] c);
      logic [23:0] e;
      logic [31:0] rsp;
      logic [31:0] rn;
      logic [7:0] a, m;
      rn = $random(seed);
      bstat <= rn[1:0];
      dstat <= rn[3:2];
      sv <= rn[15:4];
      @(posedge clk);
      case (pk)
         2'h0: e = {pn, 2'h3, 16'h0000, dstat};
         2'h1: e = {4'h6, bstat, 2'h0, pw};
         2'h2: e = {4'h4, bstat, 2'h0, pw};
         default: e = {pn, bstat, sv, 4'h0, dstat};
      endcase
      a = c[23:16];
      m = lock ? 8'h03 : 8'hff;
      pn = c[31:28];
      pw = {ref_m[{a[7:1], 1'b1}], ref_m[{a[7:1], 1'b0}]};
      pk = 2'h0;
      if (c[7:0] === crc(c[31:8]) && !err) begin
         if (pn == 4'hc) pk = 2'h1;
         else if (pn == 4'h8 && c[27:24] == 4'h0 && !a[7] &&
            (!lock || a == 8'h10)) pk = 2'h2;
         else if (pn[0]) pk = 2'h3;
      end
      if (pk == 2'h2 && !a[6]) begin
         ref_m[a] = (ref_m[a] & ~m) | (c[15:8] & m);
      end
      // Sensor input moves mid-frame; answer keeps the value at select fall
      fork
         host.xfer(c, rsp);
         begin
            repeat (40) @(posedge clk);
            sv <= ~sv;
         end
      join
      checks_done++;
      if (rsp !== {e, crc(e)}) begin
         miscompares++;
         $display("CHECK FAILED response exp %h got %h", {e, crc(e)}, rsp);
      end
   endtask

   // Command with lock, output error and CRC fault flags
   task automatic go(input logic [23:0] c, input logic l, o, b);
      lock <= l;
      err <= o;
      send({c, crc(c) ^ {7'h0, b}});
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      results();
   end

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i * 7);
         ref_m[i] = 8'(i * 7);
      end
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      go({8'h80, 8'h10, 8'h5a}, 0, 0, 0);
      go({8'hc0, 8'h10, 8'h00}, 0, 0, 0);
      go({8'h80, 8'h41, 8'ha5}, 0, 0, 0);
      go({8'hc0, 8'h40, 8'h00}, 0, 0, 0);
      go({8'h80, 8'h10, 8'hff}, 1, 0, 0);
      go({8'h80, 8'h12, 8'h33}, 1, 0, 0);
      go({8'h81, 8'h12, 8'h33}, 0, 0, 0);
      go({8'h80, 8'h90, 8'h33}, 0, 0, 0);
      go({8'h80, 8'h12, 8'h33}, 0, 1, 0);
      go({8'h80, 8'h12, 8'h33}, 0, 0, 1);
      go({8'hc0, 8'h12, 8'h00}, 0, 0, 0);
      $display("test corners done");
      for (int k = 0; k < 16; k++) go({4'(k), 20'h0}, 0, 0, 0);
      $display("test command codes done");
      for (int k = 0; k < 60; k++) begin
         r = $random(seed);
         q = $random(seed);
         n = r[3] ? {1'b1, r[4], 2'b00} : r[31:28];
         h = {n, r[27:24] & {4{&r[1:0]}}, r[2] ? 8'h10 : r[23:16], r[15:8]};
         if (n[0]) h[19:0] = 0;
         go(h, q[0] & q[1], &q[4:2], &q[7:5]);
      end
      go({8'hc0, 8'h10, 8'h00}, 0, 0, 0);
      go({8'h10, 16'h0000}, 0, 0, 0);
      $display("test random done");
      results();
   end
endmodule
